// ### gio_sense.sv
// synchronises the general io inputs and picks the vbus and detach lines
`timescale 1ns/1ps
module gio_sense #(
  parameter int N_IO = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins and selects
  input wire logic [N_IO-1:0] gio_in,
  input wire logic [4:0] vbus_sel,
  input wire logic [4:0] detach_sel,
  input wire logic bus_powered,
  // synchronised results
  gio_sense_if.src sense
);

  logic [N_IO-1:0] meta_q;
  logic [N_IO-1:0] sync_q;

  // ---------------------------------------------------------------
  // two-stage synchroniser; first stage feeds only the second
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= gio_in;
      sync_q <= meta_q;
    end
  end

  // ---------------------------------------------------------------
  // line selection
  // ---------------------------------------------------------------
  always_comb begin
    sense.vbus_present = 1'b0;
    sense.detach_req = 1'b0;
    // bus powered: running at all means vbus is there
    if (bus_powered) begin
      sense.vbus_present = 1'b1;
    end else if (usb_attach_pkg::pin_valid(vbus_sel, N_IO)) begin
      sense.vbus_present = sync_q[vbus_sel[$clog2(N_IO)-1:0]];
    end
    // unassigned detach select leaves detach inactive
    if (usb_attach_pkg::pin_valid(detach_sel, N_IO)) begin
      sense.detach_req = sync_q[detach_sel[$clog2(N_IO)-1:0]];
    end
  end

endmodule

// ### gio_sense_if.sv
// carrier for synchronised pin-derived inputs between sensing and control
`timescale 1ns/1ps
interface gio_sense_if;
  logic vbus_present;
  logic detach_req;
  modport src (output vbus_present, output detach_req);
  modport dst (input vbus_present, input detach_req);
endinterface

// ### test_usb_attach_detach_control.sv
// self-checking bench for the usb attach/detach control block
`timescale 1ns/1ps
module test_usb_attach_detach_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] gio_in = 8'h00;
  logic suspend_cmd = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [7:0] gio_out, gio_oe, max_power_units;
  logic pready, pslverr, err, usb_suspend, dp_pullup_en, usb_line_hiz, usb_core_enable;
  logic remote_wake_allow, full_speed_only, peripheral_only, audio_endpoints, radio_enable;
  int link_rate_mbps;
  int fail_count = 0;
  int cmp_count = 0;

  always #12.5 pclk = ~pclk;

  usb_attach_ctrl #(.N_IO(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gio_in(gio_in), .gio_out(gio_out), .gio_oe(gio_oe), .usb_suspend(usb_suspend),
    .dp_pullup_en(dp_pullup_en), .usb_line_hiz(usb_line_hiz),
    .usb_core_enable(usb_core_enable), .remote_wake_allow(remote_wake_allow),
    .full_speed_only(full_speed_only), .peripheral_only(peripheral_only),
    .audio_endpoints(audio_endpoints), .max_power_units(max_power_units),
    .radio_enable(radio_enable)
  );
  usb_host_model u_host (
    .pclk(pclk), .presetn(presetn), .usb_core_enable(usb_core_enable),
    .usb_line_hiz(usb_line_hiz), .full_speed_only(full_speed_only),
    .usb_suspend(usb_suspend), .link_rate_mbps(link_rate_mbps), .suspend_cmd(suspend_cmd)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic chk1(input string w, input logic s, input logic e);
    check(w, {31'h0, s}, {31'h0, e});
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    chk1("pullup", dp_pullup_en, 1'b0);
    chk1("hiz", usb_line_hiz, 1'b1);
    rdchk("ctrl", usb_attach_pkg::ADDR_CTRL, 32'h02);
    rdchk("pu src", usb_attach_pkg::ADDR_PULLUP_SRC, 32'h10);
    rdchk("vbus sel", usb_attach_pkg::ADDR_VBUS_PIN, 32'h1F);
    rdchk("det sel", usb_attach_pkg::ADDR_DETACH_PIN, 32'h1F);
    rdchk("wake sel", usb_attach_pkg::ADDR_WAKE_PIN, 32'h1F);
    rdchk("power", usb_attach_pkg::ADDR_POWER, 32'h32);
    check("power pin", max_power_units, 32'h32);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk1("wr slverr", err, 1'b1);
    rdchk("unmapped", 8'h1C, 32'h0);
    chk1("rd slverr", err, 1'b1);
    check("rate", link_rate_mbps, 32'd12);
    chk1("periph", peripheral_only, 1'b1);
    chk1("not ready", dp_pullup_en, 1'b0);
    apb(1'b1, usb_attach_pkg::ADDR_CTRL, 32'h07);
    cyc(3);
    chk1("attach", dp_pullup_en, 1'b1);
    chk1("attach hiz", usb_line_hiz, 1'b0);
    chk1("audio", audio_endpoints, 1'b1);
    apb(1'b1, usb_attach_pkg::ADDR_CTRL, 32'h1B);
    apb(1'b1, usb_attach_pkg::ADDR_DETACH_PIN, 32'h03);
    apb(1'b1, usb_attach_pkg::ADDR_WAKE_PIN, 32'h05);
    cyc(1);
    chk1("wireless", audio_endpoints, 1'b0);
    chk1("rwake", remote_wake_allow, 1'b1);
    check("wake drv", {gio_oe[5], gio_out[5]}, 32'h2);
    @(posedge pclk);
    gio_in[3] <= 1'b1;
    cyc(1);
    chk1("sync", usb_line_hiz, 1'b0);
    cyc(1);
    chk1("det hiz", usb_line_hiz, 1'b1);
    chk1("det pu", dp_pullup_en, 1'b0);
    cyc(1);
    chk1("wake out", gio_out[5], 1'b1);
    chk1("no rwake", remote_wake_allow, 1'b0);
    rdchk("status det", usb_attach_pkg::ADDR_STATUS, 32'hBB);
    @(posedge pclk);
    gio_in[3] <= 1'b0;
    cyc(5);
    chk1("reattach", dp_pullup_en, 1'b1);
    chk1("wake off", gio_out[5], 1'b0);
    @(posedge pclk);
    suspend_cmd <= 1'b1;
    cyc(3);
    chk1("radio susp", radio_enable, 1'b0);
    @(posedge pclk);
    suspend_cmd <= 1'b0;
    cyc(3);
    chk1("radio back", radio_enable, 1'b1);
    // self powered with an external pull-up on line 6
    apb(1'b1, usb_attach_pkg::ADDR_CTRL, 32'h01);
    apb(1'b1, usb_attach_pkg::ADDR_PULLUP_SRC, 32'h06);
    cyc(3);
    rdchk("self power", usb_attach_pkg::ADDR_POWER, 32'h0);
    check("self pin", max_power_units, 32'h0);
    chk1("no vbus sel", usb_core_enable, 1'b0);
    apb(1'b1, usb_attach_pkg::ADDR_VBUS_PIN, 32'h02);
    cyc(4);
    check("vbus low", {usb_core_enable, gio_oe[6]}, 32'h0);
    @(posedge pclk);
    gio_in[2] <= 1'b1;
    cyc(4);
    chk1("vbus attach", usb_core_enable, 1'b1);
    check("ext pu", {dp_pullup_en, gio_oe[6], gio_out[6]}, 32'h3);
    rdchk("status att", usb_attach_pkg::ADDR_STATUS, 32'h65);
    @(posedge pclk);
    suspend_cmd <= 1'b1;
    cyc(3);
    chk1("self radio", radio_enable, 1'b1);
    @(posedge pclk);
    suspend_cmd <= 1'b0;
    gio_in[2] <= 1'b0;
    cyc(4);
    check("vbus gone", {usb_core_enable, gio_oe[6]}, 32'h0);
    report_and_stop;
  end

  // a healthy run takes well under a thousand cycles
  initial begin
    repeat (4000) @(posedge pclk);
    fail_count++;
    report_and_stop;
  end
endmodule

bind usb_attach_ctrl usb_attach_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .usb_suspend(usb_suspend),
  .dp_pullup_en(dp_pullup_en), .usb_line_hiz(usb_line_hiz),
  .usb_core_enable(usb_core_enable), .remote_wake_allow(remote_wake_allow),
  .full_speed_only(full_speed_only), .peripheral_only(peripheral_only),
  .max_power_units(max_power_units), .radio_enable(radio_enable)
);

// ### usb_attach_chk.sv
// concurrent checks on the usb attach/detach control top ports
`timescale 1ns/1ps
module usb_attach_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // usb core side
  input wire logic usb_suspend,
  input wire logic dp_pullup_en,
  input wire logic usb_line_hiz,
  input wire logic usb_core_enable,
  input wire logic remote_wake_allow,
  input wire logic full_speed_only,
  input wire logic peripheral_only,
  input wire logic [7:0] max_power_units,
  input wire logic radio_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // bus
  // ---------------------------------------------------------------
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_ready;
    s_access |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_unmapped;
    psel && penable && paddr > 8'h18 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  // ---------------------------------------------------------------
  // connection
  // ---------------------------------------------------------------
  property p_hiz;
    usb_line_hiz |-> !dp_pullup_en && !usb_core_enable;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pull-up on while lines float");
  property p_pullup;
    dp_pullup_en |-> usb_core_enable;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on while not attached");
  property p_wake;
    remote_wake_allow |-> !usb_line_hiz;
  endproperty
  a_wake: assert property (p_wake) else $error("in-band wake while detached");
  property p_power;
    max_power_units == usb_attach_pkg::BUS_POWER_UNITS
      || max_power_units == usb_attach_pkg::SELF_POWER_UNITS;
  endproperty
  a_power: assert property (p_power) else $error("current request off scale");
  property p_full_speed;
    full_speed_only;
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("not full speed");
  property p_periph;
    peripheral_only;
  endproperty
  a_periph: assert property (p_periph) else $error("not peripheral");
  // radio may only go quiet once the host has suspended the bus
  property p_radio;
    !radio_enable |-> $past(usb_suspend);
  endproperty
  a_radio: assert property (p_radio) else $error("radio off without suspend");
endmodule

// ### usb_attach_ctrl.sv
// usb attach/detach, pull-up, wake and power control with apb registers
`timescale 1ns/1ps
module usb_attach_ctrl #(
  parameter int N_IO = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // general io lines
  input wire logic [N_IO-1:0] gio_in,
  output logic [N_IO-1:0] gio_out,
  output logic [N_IO-1:0] gio_oe,
  // usb core side
  input wire logic usb_suspend,
  output logic dp_pullup_en,
  output logic usb_line_hiz,
  output logic usb_core_enable,
  output logic remote_wake_allow,
  output logic full_speed_only,
  output logic peripheral_only,
  output logic audio_endpoints,
  output logic [7:0] max_power_units,
  output logic radio_enable
);

  logic [4:0] ctrl_q;
  logic [4:0] pullup_src_q;
  logic [4:0] vbus_sel_q;
  logic [4:0] detach_sel_q;
  logic [4:0] wake_sel_q;
  usb_attach_pkg::conn_state_t state_q;
  usb_attach_pkg::conn_state_t state_d;
  logic wr_en;
  logic rd_hit;
  logic pullup_on;
  logic wake_on;
  logic [7:0] status;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a select hits line idx only when it names a real line
  function automatic logic sel_hits(input logic [4:0] sel, input int idx);
    sel_hits = usb_attach_pkg::pin_valid(sel, N_IO) && int'(sel) == idx;
  endfunction

  gio_sense_if sense ();

  // ---------------------------------------------------------------
  // pin synchronisation and selection
  // ---------------------------------------------------------------
  // bus powered forces vbus present inside the sense block
  gio_sense #(
    .N_IO(N_IO)
  ) u_sense (
    .pclk(pclk),
    .presetn(presetn),
    .gio_in(gio_in),
    .vbus_sel(vbus_sel_q),
    .detach_sel(detach_sel_q),
    .bus_powered(ctrl_q[usb_attach_pkg::CTRL_BUS_POWERED]),
    .sense(sense.src)
  );

  // ---------------------------------------------------------------
  // apb access decode
  // ---------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      usb_attach_pkg::ADDR_CTRL,
      usb_attach_pkg::ADDR_PULLUP_SRC,
      usb_attach_pkg::ADDR_VBUS_PIN,
      usb_attach_pkg::ADDR_DETACH_PIN,
      usb_attach_pkg::ADDR_WAKE_PIN,
      usb_attach_pkg::ADDR_STATUS,
      usb_attach_pkg::ADDR_POWER: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  // error only in the access phase so setup cycles stay quiet
  assign pslverr = psel && penable && !rd_hit;

  // ---------------------------------------------------------------
  // writable settings
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // every setting returns to its power-on value
      ctrl_q <= usb_attach_pkg::CTRL_RST;
    end else if (wr_en && paddr == usb_attach_pkg::ADDR_CTRL) begin
      ctrl_q <= pwdata[usb_attach_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_src_q <= usb_attach_pkg::PULLUP_INTERNAL;
    end else if (wr_en && paddr == usb_attach_pkg::ADDR_PULLUP_SRC) begin
      pullup_src_q <= pwdata[usb_attach_pkg::SEL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // vbus, detach and wake selects above the last line leave their function unassigned
      vbus_sel_q <= usb_attach_pkg::PIN_NONE;
    end else if (wr_en && paddr == usb_attach_pkg::ADDR_VBUS_PIN) begin
      vbus_sel_q <= pwdata[usb_attach_pkg::SEL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detach_sel_q <= usb_attach_pkg::PIN_NONE;
      wake_sel_q <= usb_attach_pkg::PIN_NONE;
    end else if (wr_en) begin
      if (paddr == usb_attach_pkg::ADDR_DETACH_PIN) begin
        detach_sel_q <= pwdata[usb_attach_pkg::SEL_W-1:0];
      end
      if (paddr == usb_attach_pkg::ADDR_WAKE_PIN) begin
        wake_sel_q <= pwdata[usb_attach_pkg::SEL_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // connection state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // detach overrides everything; suspend only follows attached
    case (state_q)
      usb_attach_pkg::CONN_OFF: begin
        // announce only when ready, powered and not held detached
        if (sense.detach_req) begin
          state_d = usb_attach_pkg::CONN_DETACHED;
        end else if (ctrl_q[usb_attach_pkg::CTRL_READY] && sense.vbus_present) begin
          state_d = usb_attach_pkg::CONN_ATTACHED;
        end
      end
      usb_attach_pkg::CONN_ATTACHED: begin
        if (sense.detach_req) begin
          state_d = usb_attach_pkg::CONN_DETACHED;
        end else if (!sense.vbus_present || !ctrl_q[usb_attach_pkg::CTRL_READY]) begin
          state_d = usb_attach_pkg::CONN_OFF;
        end else if (usb_suspend) begin
          state_d = usb_attach_pkg::CONN_SUSPEND;
        end
      end
      usb_attach_pkg::CONN_SUSPEND: begin
        if (sense.detach_req) begin
          state_d = usb_attach_pkg::CONN_DETACHED;
        end else if (!sense.vbus_present || !ctrl_q[usb_attach_pkg::CTRL_READY]) begin
          state_d = usb_attach_pkg::CONN_OFF;
        end else if (!usb_suspend) begin
          state_d = usb_attach_pkg::CONN_ATTACHED;
        end
      end
      usb_attach_pkg::CONN_DETACHED: begin
        // leave through off so vbus and ready are checked again
        if (!sense.detach_req) begin
          state_d = usb_attach_pkg::CONN_OFF;
        end
      end
      default: state_d = usb_attach_pkg::CONN_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= usb_attach_pkg::CONN_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // pull-up, line and wake control
  // ---------------------------------------------------------------
  // state records the decision; live inputs still gate the outputs
  // vbus loss forces the pull-up off in the same cycle it is seen
  assign pullup_on = (state_q == usb_attach_pkg::CONN_ATTACHED
                      || state_q == usb_attach_pkg::CONN_SUSPEND)
                     && sense.vbus_present && !sense.detach_req;
  assign dp_pullup_en = pullup_on
                        && pullup_src_q == usb_attach_pkg::PULLUP_INTERNAL;
  assign usb_line_hiz = !pullup_on;
  assign usb_core_enable = pullup_on;
  assign wake_on = (state_q == usb_attach_pkg::CONN_DETACHED)
                   && ctrl_q[usb_attach_pkg::CTRL_WAKE_REQ];
  // in-band wake is impossible while off the bus
  assign remote_wake_allow = pullup_on
                             && ctrl_q[usb_attach_pkg::CTRL_REMOTE_WAKE];

  // wake pin is driven always unless the pull-up shares its line; external pull-up floats when off
  always_comb begin
    gio_out = '0;
    gio_oe = '0;
    for (int i = 0; i < N_IO; i++) begin
      if (sel_hits(wake_sel_q, i)) begin
        gio_oe[i] = 1'b1;
        gio_out[i] = wake_on;
      end
      // a shared line goes to the pull-up, whose branch comes last
      if (sel_hits(pullup_src_q, i)) begin
        gio_oe[i] = pullup_on;
        gio_out[i] = pullup_on;
      end
    end
  end

  // ---------------------------------------------------------------
  // link personality and power
  // ---------------------------------------------------------------
  // only full-speed signalling exists; a fast host falls back to it
  assign full_speed_only = 1'b1;
  // no host role: the core may only answer tokens
  assign peripheral_only = 1'b1;
  assign audio_endpoints = ctrl_q[usb_attach_pkg::CTRL_AUDIO_EP];
  // self powered parts keep the radio running through suspend
  assign radio_enable = !(ctrl_q[usb_attach_pkg::CTRL_BUS_POWERED]
                          && state_q == usb_attach_pkg::CONN_SUSPEND);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_power_units <= usb_attach_pkg::SELF_POWER_UNITS;
    end else if (ctrl_q[usb_attach_pkg::CTRL_BUS_POWERED]) begin
      // registered so a ctrl write never glitches the request
      max_power_units <= usb_attach_pkg::BUS_POWER_UNITS;
    end else begin
      max_power_units <= usb_attach_pkg::SELF_POWER_UNITS;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    status = '0;
    status[usb_attach_pkg::ST_VBUS] = sense.vbus_present;
    status[usb_attach_pkg::ST_DETACH] = sense.detach_req;
    status[usb_attach_pkg::ST_PULLUP] = pullup_on;
    status[usb_attach_pkg::ST_HIZ] = usb_line_hiz;
    status[usb_attach_pkg::ST_WAKE] = wake_on;
    status[usb_attach_pkg::ST_RADIO] = radio_enable;
    status[usb_attach_pkg::ST_STATE_LO +: 2] = state_q;
  end

  always_comb begin
    rdata_d = '0;
    // reserved bits read as zero
    case (paddr)
      usb_attach_pkg::ADDR_CTRL: rdata_d[4:0] = ctrl_q;
      usb_attach_pkg::ADDR_PULLUP_SRC: rdata_d[4:0] = pullup_src_q;
      usb_attach_pkg::ADDR_VBUS_PIN: rdata_d[4:0] = vbus_sel_q;
      usb_attach_pkg::ADDR_DETACH_PIN: rdata_d[4:0] = detach_sel_q;
      usb_attach_pkg::ADDR_WAKE_PIN: rdata_d[4:0] = wake_sel_q;
      usb_attach_pkg::ADDR_STATUS: rdata_d[usb_attach_pkg::ST_W-1:0] = status;
      usb_attach_pkg::ADDR_POWER: rdata_d[7:0] = max_power_units;
      default: rdata_d = '0;
    endcase
  end

  // data captured in the setup cycle, valid during the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

endmodule

// ### usb_attach_pkg.sv
// shared constants, register map and types for the usb attach/detach control block
package usb_attach_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PULLUP_SRC = 8'h04;
  localparam logic [7:0] ADDR_VBUS_PIN = 8'h08;
  localparam logic [7:0] ADDR_DETACH_PIN = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_PIN = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_POWER = 8'h18;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_READY = 0;
  localparam int CTRL_BUS_POWERED = 1;
  localparam int CTRL_AUDIO_EP = 2;
  localparam int CTRL_WAKE_REQ = 3;
  localparam int CTRL_REMOTE_WAKE = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h02;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int ST_VBUS = 0;
  localparam int ST_DETACH = 1;
  localparam int ST_PULLUP = 2;
  localparam int ST_HIZ = 3;
  localparam int ST_WAKE = 4;
  localparam int ST_RADIO = 5;
  localparam int ST_STATE_LO = 6;
  localparam int ST_W = 8;

  // ---------------------------------------------------------------
  // pin selects; a value of 16 means the internal pull-up
  // ---------------------------------------------------------------
  localparam int SEL_W = 5;
  localparam logic [4:0] PULLUP_INTERNAL = 5'h10;
  localparam logic [4:0] PIN_NONE = 5'h1F;

  // ---------------------------------------------------------------
  // bus-powered current request, reported in 2 mA descriptor units
  // ---------------------------------------------------------------
  localparam int BUS_CURRENT_MA = 100;
  localparam int POWER_UNIT_MA = 2;
  localparam logic [7:0] BUS_POWER_UNITS = 8'(BUS_CURRENT_MA / POWER_UNIT_MA);
  localparam logic [7:0] SELF_POWER_UNITS = 8'h00;
  localparam int LINK_RATE_MBPS = 12;

  // ---------------------------------------------------------------
  // connection state, gray coded around the usual path
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CONN_OFF = 2'b00,
    CONN_ATTACHED = 2'b01,
    CONN_SUSPEND = 2'b11,
    CONN_DETACHED = 2'b10
  } conn_state_t;

  // true when a select names a real general io line
  function automatic logic pin_valid(input logic [4:0] sel, input int n_io);
    pin_valid = (int'(sel) < n_io);
  endfunction

endpackage

// ### usb_host_model.sv
// host model: suspends an attached device on request, full-speed link
`timescale 1ns/1ps
module usb_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // device side
  input wire logic usb_core_enable,
  input wire logic usb_line_hiz,
  input wire logic full_speed_only,
  output logic usb_suspend,
  output int link_rate_mbps,
  // bench control
  input wire logic suspend_cmd
);
  // a host can only suspend a device it sees; unplugging ends suspend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_suspend <= 1'b0;
    end else begin
      usb_suspend <= suspend_cmd && !usb_line_hiz && (usb_suspend || usb_core_enable);
    end
  end
  assign link_rate_mbps = full_speed_only ? 12 : 480;
endmodule
